// >>> hw/fcs_top.sv
// flash command sequencer: avalon-mm slave, command engine and array
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fcs_top #(
  parameter int unsigned P_PAGE_ERASE_CYC = fcs_pkg::PAGE_ERASE_NS / fcs_pkg::CLK_PERIOD_NS,
  parameter int unsigned P_MASS_ERASE_CYC = fcs_pkg::MASS_ERASE_NS / fcs_pkg::CLK_PERIOD_NS,
  parameter int unsigned P_WORD_PROG_CYC = fcs_pkg::WORD_PROG_NS / fcs_pkg::CLK_PERIOD_NS,
  parameter int unsigned P_BURST_STEP_CYC = fcs_pkg::BURST_STEP_NS / fcs_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // avalon-mm slave
  input wire fcs_pkg::fcs_avs_req_t I_AVS_REQ,
  output logic O_AVS_WAITREQUEST,
  output logic [fcs_pkg::DATA_W-1:0] O_AVS_READDATA,
  // interrupt request
  output logic O_IRQ
);

  // register address match inside the register window
  function automatic logic reg_hit(input logic [fcs_pkg::BUS_AW-1:0] a,
                                   input logic [7:0] off);
    reg_hit = !a[fcs_pkg::REGION_BIT] && (a[17:0] == {fcs_pkg::REG_HI_ZERO, off});
  endfunction

  // defined command codes
  function automatic logic is_known(input logic [fcs_pkg::DATA_W-1:0] c);
    is_known = (c == fcs_pkg::PAGE_ERASE_CMD) ||
               (c == fcs_pkg::FULL_ARRAY_ERASE_CMD) ||
               (c == fcs_pkg::WORD_PROGRAM_CMD) ||
               (c == fcs_pkg::QUAD_WORD_PROGRAM_CMD);
  endfunction

  // software visible state
  logic [fcs_pkg::DATA_W-1:0] cmd_reg;
  logic [fcs_pkg::ADDR_W-1:0] prog_addr;
  logic [3:0][fcs_pkg::DATA_W-1:0] program_word;
  logic [fcs_pkg::FLAG_W-1:0] unmasked_flag_view;
  logic [fcs_pkg::FLAG_W-1:0] flag_enable_mask;

  // bus handshake state
  logic ack;
  logic [fcs_pkg::DATA_W-1:0] rd_data;

  // sequencer state
  fcs_pkg::fcs_state_t state;
  fcs_pkg::fcs_state_t next_state;
  logic [fcs_pkg::DATA_W-1:0] op;
  logic [fcs_pkg::DATA_W-1:0] next_op;
  logic [fcs_pkg::ADDR_W-1:0] ptr;
  logic [fcs_pkg::ADDR_W-1:0] next_ptr;
  logic [fcs_pkg::ADDR_W-1:0] last;
  logic [fcs_pkg::ADDR_W-1:0] next_last;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic first;
  logic next_first;
  logic op_end;
  fcs_pkg::fcs_arr_wr_t arr_wr;
  logic [fcs_pkg::DATA_W-1:0] arr_rd;

  // request decode
  wire rd = I_AVS_REQ.read;
  wire wr = I_AVS_REQ.write;
  wire [fcs_pkg::BUS_AW-1:0] adr = I_AVS_REQ.address;
  wire [fcs_pkg::DATA_W-1:0] wdata = I_AVS_REQ.writedata;
  wire in_array = adr[fcs_pkg::REGION_BIT];
  wire [fcs_pkg::ADDR_W-1:0] arr_word_addr = adr[17:2];
  wire busy = (state != fcs_pkg::SEQ_IDLE);

  wire hit_cmd = reg_hit(adr, fcs_pkg::OFF_COMMAND);
  wire hit_masked = reg_hit(adr, fcs_pkg::OFF_MASKED_VIEW);
  wire hit_mask = reg_hit(adr, fcs_pkg::OFF_ENABLE_MASK);
  wire hit_raw = reg_hit(adr, fcs_pkg::OFF_UNMASKED_VIEW);
  wire hit_size = reg_hit(adr, fcs_pkg::OFF_SIZE);
  wire hit_addr = reg_hit(adr, fcs_pkg::OFF_PROG_ADDR);
  wire hit_w0 = reg_hit(adr, fcs_pkg::OFF_WORD_0);
  wire hit_w1 = reg_hit(adr, fcs_pkg::OFF_WORD_1);
  wire hit_w2 = reg_hit(adr, fcs_pkg::OFF_WORD_2);
  wire hit_w3 = reg_hit(adr, fcs_pkg::OFF_WORD_3);

  // array reads wait out a running operation instead of seeing stale data
  wire stall = rd && in_array && busy;
  wire next_ack = (rd || wr) && !ack && !stall;
  wire bus_wr = wr && ack;

  assign O_AVS_WAITREQUEST = (rd || wr) && !ack;

  // command acceptance
  wire cmd_wr = bus_wr && hit_cmd;
  wire known = is_known(wdata);
  wire start_go = cmd_wr && !busy && known;
  wire is_quad = (op == fcs_pkg::QUAD_WORD_PROGRAM_CMD);

  // programming address decomposition
  wire [6:0] page_row_index_page = prog_addr[15:fcs_pkg::PAGE_LSB];
  wire [2:0] page_row_index_row = prog_addr[8:fcs_pkg::ROW_LSB];
  wire [5:0] word_in_row_index = prog_addr[5:0];
  wire [fcs_pkg::ADDR_W-1:0] page_first = {page_row_index_page, fcs_pkg::PAGE_OFS_ZERO};
  wire [fcs_pkg::ADDR_W-1:0] page_last = {page_row_index_page, fcs_pkg::PAGE_OFS_LAST};
  wire [fcs_pkg::ADDR_W-1:0] word_target =
    {page_row_index_page, page_row_index_row, word_in_row_index} + {13'h0000, idx};
  wire [2:0] last_idx = is_quad ? 3'h3 : 3'h0;
  wire [fcs_pkg::DATA_W-1:0] cur_word = program_word[idx[1:0]];
  wire skip_word = is_quad && (cur_word == fcs_pkg::WORD_ALL_ONES);

  // flag events; a set in the same cycle as a clear wins
  wire [fcs_pkg::FLAG_W-1:0] flag_set;
  assign flag_set[fcs_pkg::FLAG_FINISHED] = op_end;
  assign flag_set[fcs_pkg::FLAG_STARTED] = start_go;
  assign flag_set[fcs_pkg::FLAG_WHILE_BUSY] = cmd_wr && busy;
  assign flag_set[fcs_pkg::FLAG_UNKNOWN] = cmd_wr && !busy && !known;
  assign flag_set[5:4] = 2'h0;

  wire flag_clr_wr = bus_wr && (hit_masked || hit_raw);
  wire [fcs_pkg::FLAG_W-1:0] flag_clr =
    flag_clr_wr ? wdata[fcs_pkg::FLAG_W-1:0] : fcs_pkg::FLAGS_NONE;
  wire [fcs_pkg::FLAG_W-1:0] next_flags = (unmasked_flag_view & ~flag_clr) | flag_set;
  wire [fcs_pkg::FLAG_W-1:0] masked_flag_view = unmasked_flag_view & flag_enable_mask;

  assign O_IRQ = |masked_flag_view;

  // register read selection; unmapped offsets read zero
  wire [fcs_pkg::DATA_W-1:0] reg_rd =
    hit_cmd ? cmd_reg :
    hit_masked ? {26'h0000000, masked_flag_view} :
    hit_mask ? {26'h0000000, flag_enable_mask} :
    hit_raw ? {26'h0000000, unmasked_flag_view} :
    hit_size ? fcs_pkg::SIZE_VALUE :
    hit_addr ? {16'h0000, prog_addr} :
    hit_w0 ? program_word[0] :
    hit_w1 ? program_word[1] :
    hit_w2 ? program_word[2] :
    hit_w3 ? program_word[3] :
    fcs_pkg::WORD_ZERO;
  wire [fcs_pkg::DATA_W-1:0] next_rd = in_array ? arr_rd : reg_rd;

  // sequencer next state
  always_comb begin
    next_state = state;
    next_op = op;
    next_ptr = ptr;
    next_last = last;
    next_idx = idx;
    next_timer = timer;
    next_first = first;
    op_end = 1'b0;
    arr_wr.en = 1'b0;
    arr_wr.erase = 1'b0;
    arr_wr.addr = ptr;
    arr_wr.data = fcs_pkg::WORD_ALL_ONES;
    case (state)
      fcs_pkg::SEQ_IDLE: begin
        if (start_go) begin
          next_op = wdata;
          next_idx = 3'h0;
          next_first = 1'b1;
          if (wdata == fcs_pkg::PAGE_ERASE_CMD) begin
            // low bits are forced to zero so a sloppy address still erases one page
            next_ptr = page_first;
            next_last = page_last;
            next_state = fcs_pkg::SEQ_ERASE;
          end else if (wdata == fcs_pkg::FULL_ARRAY_ERASE_CMD) begin
            next_ptr = fcs_pkg::ARR_FIRST;
            next_last = fcs_pkg::ARR_LAST;
            next_state = fcs_pkg::SEQ_ERASE;
          end else begin
            next_state = fcs_pkg::SEQ_PROG;
          end
        end
      end
      fcs_pkg::SEQ_ERASE: begin
        // one word per cycle; the erase time is waited out afterwards
        arr_wr.en = 1'b1;
        arr_wr.erase = 1'b1;
        if (ptr == last) begin
          next_timer = (op == fcs_pkg::FULL_ARRAY_ERASE_CMD) ? P_MASS_ERASE_CYC
                                                              : P_PAGE_ERASE_CYC;
          next_state = fcs_pkg::SEQ_ERASE_WAIT;
        end else begin
          next_ptr = ptr + 16'h0001;
        end
      end
      fcs_pkg::SEQ_ERASE_WAIT: begin
        if (timer == 32'h0000_0000) begin
          op_end = 1'b1;
          next_state = fcs_pkg::SEQ_IDLE;
        end else begin
          next_timer = timer - 32'h0000_0001;
        end
      end
      fcs_pkg::SEQ_PROG: begin
        if (idx > last_idx) begin
          op_end = 1'b1;
          next_state = fcs_pkg::SEQ_IDLE;
        end else if (skip_word) begin
          next_idx = idx + 3'h1;
        end else begin
          arr_wr.en = 1'b1;
          arr_wr.addr = word_target;
          arr_wr.data = cur_word;
          // later words of a burst cost only the step time
          next_timer = first ? P_WORD_PROG_CYC : P_BURST_STEP_CYC;
          next_first = 1'b0;
          next_state = fcs_pkg::SEQ_PROG_WAIT;
        end
      end
      fcs_pkg::SEQ_PROG_WAIT: begin
        if (timer == 32'h0000_0000) begin
          next_idx = idx + 3'h1;
          next_state = fcs_pkg::SEQ_PROG;
        end else begin
          next_timer = timer - 32'h0000_0001;
        end
      end
      default: begin
        next_state = fcs_pkg::SEQ_IDLE;
      end
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ack <= 1'b0;
      rd_data <= fcs_pkg::WORD_ZERO;
    end else begin
      ack <= next_ack;
      if (next_ack && rd) begin
        rd_data <= next_rd;
      end
    end
  end

  assign O_AVS_READDATA = rd_data;

  // write strobes for the programming address, the enable mask and the four program words
  wire we_addr = bus_wr && hit_addr;
  wire we_mask = bus_wr && hit_mask;
  wire [3:0] we_word = {hit_w3, hit_w2, hit_w1, hit_w0} & {4{bus_wr}};

  // flag register; an event beats a same-cycle clear
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      unmasked_flag_view <= fcs_pkg::FLAGS_NONE;
    end else begin
      unmasked_flag_view <= next_flags;
    end
  end

  // a refused command still lands here, so software can see what it wrote
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cmd_reg <= fcs_pkg::WORD_ZERO;
    end else if (cmd_wr) begin
      cmd_reg <= wdata;
    end
  end

  // programming address and enable mask
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prog_addr <= fcs_pkg::ARR_FIRST;
      flag_enable_mask <= fcs_pkg::MASK_RESET;
    end else begin
      if (we_addr) begin
        prog_addr <= wdata[fcs_pkg::ADDR_W-1:0];
      end
      if (we_mask) begin
        flag_enable_mask <= wdata[fcs_pkg::FLAG_W-1:0];
      end
    end
  end

  // program words; software must leave them alone while a program runs
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      program_word <= {4{fcs_pkg::WORD_ALL_ONES}};
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (we_word[n]) begin
          program_word[n] <= wdata;
        end
      end
    end
  end

  // sequencer registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state <= fcs_pkg::SEQ_IDLE;
      op <= fcs_pkg::WORD_ZERO;
      ptr <= fcs_pkg::ARR_FIRST;
      last <= fcs_pkg::ARR_FIRST;
      idx <= 3'h0;
      timer <= 32'h0000_0000;
      first <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      ptr <= next_ptr;
      last <= next_last;
      idx <= next_idx;
      timer <= next_timer;
      first <= next_first;
    end
  end

  // array; bus reads never overlap writes because reads stall while busy
  fcs_array u_array (
    .i_clk(I_CLK),
    .i_wr(arr_wr),
    .i_rd_addr(arr_word_addr),
    .o_rd_data(arr_rd)
  );

endmodule // fcs_top
`default_nettype wire

// >>> hw/fcs_pkg.sv
// constants, types and register map of the flash command sequencer
package fcs_pkg;

  // array geometry: pages of rows of words
  localparam int PAGE_COUNT = 128;
  localparam int ROWS_PER_PAGE = 8;
  localparam int WORDS_PER_ROW = 64;
  localparam int ARR_WORDS = PAGE_COUNT * ROWS_PER_PAGE * WORDS_PER_ROW;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PAGE_LSB = 9;
  localparam int ROW_LSB = 6;
  localparam logic [8:0] PAGE_OFS_ZERO = 9'h000;
  localparam logic [8:0] PAGE_OFS_LAST = 9'h1FF;
  localparam logic [ADDR_W-1:0] ARR_FIRST = 16'h0000;
  localparam logic [ADDR_W-1:0] ARR_LAST = 16'hFFFF;

  // bus address: byte address, top bit selects the array window
  localparam int BUS_AW = 19;
  localparam int REGION_BIT = 18;
  localparam logic [9:0] REG_HI_ZERO = 10'h000;

  // register byte offsets
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_MASKED_VIEW = 8'h08;
  localparam logic [7:0] OFF_ENABLE_MASK = 8'h0C;
  localparam logic [7:0] OFF_UNMASKED_VIEW = 8'h10;
  localparam logic [7:0] OFF_SIZE = 8'h14;
  localparam logic [7:0] OFF_PROG_ADDR = 8'h18;
  localparam logic [7:0] OFF_WORD_0 = 8'h40;
  localparam logic [7:0] OFF_WORD_1 = 8'h44;
  localparam logic [7:0] OFF_WORD_2 = 8'h48;
  localparam logic [7:0] OFF_WORD_3 = 8'h4C;

  // command codes
  localparam logic [31:0] PAGE_ERASE_CMD = 32'h0000_0011;
  localparam logic [31:0] FULL_ARRAY_ERASE_CMD = 32'h0000_0022;
  localparam logic [31:0] WORD_PROGRAM_CMD = 32'h0000_0033;
  localparam logic [31:0] QUAD_WORD_PROGRAM_CMD = 32'h0000_00CC;

  // flag positions and reset values
  localparam int FLAG_W = 6;
  localparam int FLAG_FINISHED = 0;
  localparam int FLAG_STARTED = 1;
  localparam int FLAG_WHILE_BUSY = 2;
  localparam int FLAG_UNKNOWN = 3;
  localparam logic [FLAG_W-1:0] MASK_RESET = 6'h3F;
  localparam logic [FLAG_W-1:0] FLAGS_NONE = 6'h00;
  localparam logic [DATA_W-1:0] WORD_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SIZE_VALUE = 32'h0000_FFFF;

  // timing, as maximum times in ns at a 5 ns clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int PAGE_ERASE_NS = 21_500_000;
  localparam int MASS_ERASE_NS = 21_500_000;
  localparam int WORD_PROG_NS = 44_000;
  localparam int BURST_STEP_NS = 21_000;

  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ERASE = 3'b001,
    SEQ_ERASE_WAIT = 3'b010,
    SEQ_PROG = 3'b011,
    SEQ_PROG_WAIT = 3'b100
  } fcs_state_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [BUS_AW-1:0] address;
    logic [DATA_W-1:0] writedata;
  } fcs_avs_req_t;

  // one write into the array
  typedef struct packed {
    logic en;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_arr_wr_t;

endpackage

// >>> hw/fcs_array.sv
// flash array storage with program-only-clears and erase-to-ones writes
`timescale 1ns/1ps
`default_nettype none
module fcs_array (
  // clock
  input wire logic i_clk,
  // write port
  input wire fcs_pkg::fcs_arr_wr_t i_wr,
  // read port
  input wire logic [fcs_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [fcs_pkg::DATA_W-1:0] o_rd_data
);
  logic [fcs_pkg::DATA_W-1:0] mem [fcs_pkg::ARR_WORDS];
  wire [fcs_pkg::DATA_W-1:0] cur = mem[i_wr.addr];
  // programming can only pull bits low; erase is the only way back up
  wire [fcs_pkg::DATA_W-1:0] next_word = i_wr.erase ? fcs_pkg::WORD_ALL_ONES
                                                    : (cur & i_wr.data);

  always_ff @(posedge i_clk) begin
    if (i_wr.en) begin
      mem[i_wr.addr] <= next_word;
    end
  end

  // asynchronous read; the sequencer registers it onto the bus
  assign o_rd_data = mem[i_rd_addr];
endmodule // fcs_array
`default_nettype wire

// >>> verification/fcs_top_chk.sv
// port-level assertion checker for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_top_chk (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // avalon-mm slave and interrupt
  input wire fcs_pkg::fcs_avs_req_t I_AVS_REQ,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [fcs_pkg::DATA_W-1:0] O_AVS_READDATA,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic [5:0] mask_sh;
  wire req = I_AVS_REQ.read | I_AVS_REQ.write;
  wire wr_acc = I_AVS_REQ.write & ~O_AVS_WAITREQUEST;
  wire [31:0] wd = I_AVS_REQ.writedata;
  wire reg_sel = ~I_AVS_REQ.address[18];
  wire cmd_wr = wr_acc & (I_AVS_REQ.address == 19'h00000);
  wire code_ok = (wd == fcs_pkg::PAGE_ERASE_CMD) | (wd == fcs_pkg::FULL_ARRAY_ERASE_CMD) |
    (wd == fcs_pkg::WORD_PROGRAM_CMD) | (wd == fcs_pkg::QUAD_WORD_PROGRAM_CMD);
  // shadow of the enable mask, so irq checks hold whatever software masks
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mask_sh <= fcs_pkg::MASK_RESET;
    end else if (wr_acc && I_AVS_REQ.address == 19'h0000C) begin
      mask_sh <= wd[5:0];
    end
  end
  AST_IDLE_NO_WAIT: assert property (!req |-> !O_AVS_WAITREQUEST)
    else $error("waitrequest high without a request");
  AST_NEW_REQ_WAITS: assert property ($rose(req) |-> O_AVS_WAITREQUEST)
    else $error("request answered in its first cycle");
  AST_ONE_ACK: assert property ((req && !O_AVS_WAITREQUEST) ##1 req |-> O_AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  AST_REG_NO_STALL: assert property ($rose(req) && reg_sel |=> !O_AVS_WAITREQUEST)
    else $error("register access stalled");
  AST_RDATA_HOLD: assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_REQ.read))
    else $error("read data changed without a read");
  AST_IRQ_AFTER_RESET: assert property ($fell(I_RST) |-> !O_IRQ)
    else $error("irq high after reset");
  AST_UNKNOWN_CMD: assert property (cmd_wr && !code_ok && mask_sh[3] && mask_sh[2] |=> O_IRQ)
    else $error("unknown command raised no flag");
  AST_CMD_START: assert property (cmd_wr && code_ok && mask_sh[1] && mask_sh[2] |=> O_IRQ)
    else $error("command raised neither started nor busy flag");
  AST_MASK_OFF: assert property (mask_sh == 6'h00 |-> !O_IRQ)
    else $error("irq high with every flag masked");
  COV_QUAD: cover property (cmd_wr && wd == fcs_pkg::QUAD_WORD_PROGRAM_CMD);
  COV_STALL: cover property (I_AVS_REQ.read && !reg_sel && O_AVS_WAITREQUEST [*3]);
  COV_MASKED: cover property (mask_sh == 6'h00 && cmd_wr);
endmodule // fcs_top_chk
bind fcs_top fcs_top_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_REQ(I_AVS_REQ),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_AVS_READDATA(O_AVS_READDATA), .O_IRQ(O_IRQ));
`default_nettype wire

// >>> verification/fcs_host_model.sv
// processor-side avalon-mm master model
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model (
  // clock
  input wire logic i_clk,
  // avalon-mm master side
  output var fcs_pkg::fcs_avs_req_t o_req,
  input wire logic i_waitrequest,
  input wire logic [fcs_pkg::DATA_W-1:0] i_readdata
);
  initial o_req = '0;
  // no own timeout: a stalled array read may legally last a full erase
  task automatic xfer(input logic rd, input logic [18:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    o_req <= '{read: rd, write: ~rd, address: a, writedata: d};
    do @(posedge i_clk); while (i_waitrequest !== 1'b0);
    q = i_readdata;
    o_req <= '0;
  endtask
endmodule // fcs_host_model
`default_nettype wire

// >>> verification/fcs_top_bench.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fcs_pkg::fcs_avs_req_t req;
  logic wreq;
  logic irq;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] wq [4] = '{32'h11112222, 32'hFFFFFFFF, 32'h33334444, 32'h55556666};
  int num_errors = 0;
  int n_tests = 0;
  // short erase and program waits keep the run small
  fcs_top #(.P_PAGE_ERASE_CYC(20), .P_MASS_ERASE_CYC(20), .P_WORD_PROG_CYC(5),
    .P_BURST_STEP_CYC(3)) u_dut (.I_CLK(clk), .I_RST(rst), .I_AVS_REQ(req),
    .O_AVS_WAITREQUEST(wreq), .O_AVS_READDATA(rdata), .O_IRQ(irq));
  fcs_host_model u_host (.i_clk(clk), .o_req(req), .i_waitrequest(wreq), .i_readdata(rdata));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [18:0] a, input logic [31:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rc(input logic [18:0] a, input logic [31:0] exp);
    u_host.xfer(1'b1, a, 32'h0, q);
    chk(q, exp);
  endtask
  function automatic logic [18:0] aw(input logic [15:0] w);
    return {1'b1, w, 2'b00};
  endfunction
  // irq follows flag registers, so look once the edge has settled
  task automatic irq_chk(input logic exp);
    @(posedge clk);
    #1 chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic wait_flag(input int b);
    do u_host.xfer(1'b1, 19'h00010, 32'h0, q); while (q[b] !== 1'b1);
  endtask
  task automatic finish_cmd();
    wait_flag(fcs_pkg::FLAG_STARTED);
    wr(19'h00008, 32'h2);
    wait_flag(fcs_pkg::FLAG_FINISHED);
    wr(19'h00008, 32'h1);
    rc(19'h00010, 32'h0);
  endtask
  task automatic prog1(input logic [15:0] a, input logic [31:0] d);
    wr(19'h00018, {16'h0, a});
    wr(19'h00040, d);
    wr(19'h00000, fcs_pkg::WORD_PROGRAM_CMD);
    finish_cmd();
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #(90000 * 5);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(19'h0000C, 32'h3F);
    rc(19'h00014, fcs_pkg::SIZE_VALUE);
    rc(19'h00010, 32'h0);
    rc(19'h00004, 32'h0);
    for (int i = 0; i < 4; i++) rc(19'h00040 + 19'(4 * i), 32'hFFFFFFFF);
    $display("done: reset values");
    wr(19'h00018, 32'h0A00);
    wr(19'h00000, fcs_pkg::FULL_ARRAY_ERASE_CMD);
    wr(19'h00000, fcs_pkg::PAGE_ERASE_CMD);
    rc(19'h00010, 32'h6);
    irq_chk(1'b1);
    wr(19'h00010, 32'h4);
    rc(aw(16'hFFFF), 32'hFFFFFFFF);
    rc(aw(16'h0000), 32'hFFFFFFFF);
    finish_cmd();
    irq_chk(1'b0);
    $display("done: full erase");
    prog1(16'h0A05, 32'h12345678);
    prog1(16'h0A05, 32'h0F0F0F0F);
    rc(aw(16'h0A05), 32'h02040608);
    prog1(16'h09FF, 32'hA5A5A5A5);
    prog1(16'h0C00, 32'h5A5A5A5A);
    wr(19'h00018, 32'h0A3E);
    for (int i = 0; i < 4; i++) wr(19'h00040 + 19'(4 * i), wq[i]);
    wr(19'h00000, fcs_pkg::QUAD_WORD_PROGRAM_CMD);
    finish_cmd();
    for (int i = 0; i < 4; i++) rc(aw(16'h0A3E + 16'(i)), wq[i]);
    $display("done: programming");
    wr(19'h00018, 32'h0A00);
    wr(19'h00000, fcs_pkg::PAGE_ERASE_CMD);
    finish_cmd();
    rc(aw(16'h0A05), 32'hFFFFFFFF);
    rc(aw(16'h0A41), 32'hFFFFFFFF);
    rc(aw(16'h09FF), 32'hA5A5A5A5);
    rc(aw(16'h0C00), 32'h5A5A5A5A);
    $display("done: page erase");
    wr(19'h00000, 32'h00000055);
    rc(19'h00000, 32'h55);
    rc(19'h00010, 32'h8);
    wr(19'h0000C, 32'h0);
    wr(19'h00000, 32'h00000077);
    irq_chk(1'b0);
    rc(19'h00008, 32'h0);
    wr(19'h0000C, 32'h8);
    rc(19'h00008, 32'h8);
    irq_chk(1'b1);
    wr(19'h00008, 32'h8);
    rc(19'h00010, 32'h0);
    irq_chk(1'b0);
    $display("done: flags and mask");
    end_of_test();
  end
endmodule // fcs_top_bench
`default_nettype wire
